//--- src/adc_control_and_result_regs.sv
// Converter control and result registers with an APB slave port
//
// Overview of operation
// - 12-bit result lives in two read-only bytes; writes never change them.
// - Justify 0: high=bits 11..4, low upper nibble=3..0; justify 1: right aligned.
// - Result bit positions not carrying data read as zero.
// - Result registers show the new value as soon as conversion ends.
// - One conversion core shared; exactly one source routed at a time.
// - Source chosen by channel field and internal reference select bit.
// - Internal reference select routes band gap voltage instead of a pin.
// - Pin enable bit 1 makes pin analog and drops its other function.
// - Analog pins always have their pull-high resistor disconnected.
// - Power-down bit must be 0 to convert; 1 switches the core off.
// - Start bit low-high-low pulse begins a conversion after completion.
// - Start held high holds converter in reset, pending flag stays 1.
// - Conversion end clears pending flag and raises converter interrupt request.
// - Clock field divides system clock by 1 to 64; code 111 unused.
`timescale 1ns/1ps
module adc_control_and_result_regs #(
  parameter int RESULT_WIDTH = 12,
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Conversion core
  input wire logic [RESULT_WIDTH-1:0] core_result_i,
  output logic core_reset_o,
  output logic core_power_down_o,
  output logic core_clk_en_o,
  output logic core_sample_o,
  output logic [2:0] core_channel_o,
  output logic core_band_gap_sel_o,
  output logic band_gap_enable_o,
  output logic reference_source_select_o,
  // Shared pins
  output logic [PIN_COUNT-1:0] pin_analog_o,
  output logic [PIN_COUNT-1:0] pull_high_block_o,
  // Interrupt
  output logic irq_o
);
  typedef enum {IDLE, CONVERT} conv_state_e;

  adc_ctrl_pkg::control_0_s ctl0_r;
  adc_ctrl_pkg::control_1_s ctl1_r;
  logic [PIN_COUNT-1:0] pin_enable_r;
  logic [RESULT_WIDTH-1:0] result_r;
  logic irq_status_r;
  logic irq_mask_r;
  conv_state_e state_r;
  logic [5:0] div_cnt_r;
  logic [3:0] bit_cnt_r;
  logic armed_r;
  logic done_pulse;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [5:0] div_limit;
  logic div_tick;
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic [7:0] wbyte;
  // Write commit: access phase with ready high
  logic wr_commit;
  logic [7:0] ctl0_rd;
  logic [7:0] ctl1_rd;
  logic [31:0] rd_word;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign wr_commit = wr_en && pready_o;
  assign wbyte = pwdata_i[7:0];

  // Decoded register window; anything else answers with an error
  always_comb begin
    case (paddr_i)
      adc_ctrl_pkg::RESULT_LOW_ADDR,
      adc_ctrl_pkg::RESULT_HIGH_ADDR,
      adc_ctrl_pkg::CONTROL_0_ADDR,
      adc_ctrl_pkg::CONTROL_1_ADDR,
      adc_ctrl_pkg::PIN_ENABLE_ADDR,
      adc_ctrl_pkg::IRQ_STATUS_ADDR,
      adc_ctrl_pkg::IRQ_MASK_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Result byte layout by justification
  always_comb begin
    if (ctl0_r.justify) begin
      res_high = {4'h0, result_r[11:8]};
      res_low = result_r[7:0];
    end else begin
      res_high = result_r[11:4];
      res_low = {result_r[3:0], 4'h0};
    end
  end

  // Read views of the control registers
  assign ctl0_rd = {ctl0_r.start, ctl0_r.pending, ctl0_r.power_down, ctl0_r.justify, 1'b0, ctl0_r.channel};
  assign ctl1_rd = {ctl1_r.int_ref, ctl1_r.band_gap, 1'b0, ctl1_r.ref_source, 1'b0, ctl1_r.clk_div};

  // Read data mux; result bytes are only ever seen through it
  always_comb begin
    case (paddr_i)
      adc_ctrl_pkg::RESULT_LOW_ADDR: rd_word = {24'h000000, res_low};
      adc_ctrl_pkg::RESULT_HIGH_ADDR: rd_word = {24'h000000, res_high};
      adc_ctrl_pkg::CONTROL_0_ADDR: rd_word = {24'h000000, ctl0_rd};
      adc_ctrl_pkg::CONTROL_1_ADDR: rd_word = {24'h000000, ctl1_rd};
      adc_ctrl_pkg::PIN_ENABLE_ADDR: rd_word = {24'h000000, pin_enable_r};
      adc_ctrl_pkg::IRQ_STATUS_ADDR: rd_word = {31'h00000000, irq_status_r};
      adc_ctrl_pkg::IRQ_MASK_ADDR: rd_word = {31'h00000000, irq_mask_r};
      default: rd_word = 32'h00000000;
    endcase
  end

  // APB answer: zero wait states, data registered in setup phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      if (rd_en) begin
        prdata_o <= rd_word;
      end
    end
  end

  // Control register writes; result addresses have no write path
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl0_r.start <= 1'b0;
      ctl0_r.power_down <= adc_ctrl_pkg::CONTROL_0_RESET[adc_ctrl_pkg::POWER_DOWN_BIT];
      ctl0_r.justify <= 1'b0;
      ctl0_r.channel <= 3'h0;
    end else if (wr_commit && paddr_i == adc_ctrl_pkg::CONTROL_0_ADDR) begin
      ctl0_r.start <= wbyte[adc_ctrl_pkg::START_BIT];
      ctl0_r.power_down <= wbyte[adc_ctrl_pkg::POWER_DOWN_BIT];
      ctl0_r.justify <= wbyte[adc_ctrl_pkg::JUSTIFY_BIT];
      ctl0_r.channel <= wbyte[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl1_r <= '0;
    end else if (wr_commit && paddr_i == adc_ctrl_pkg::CONTROL_1_ADDR) begin
      ctl1_r.int_ref <= wbyte[adc_ctrl_pkg::INT_REF_BIT];
      ctl1_r.band_gap <= wbyte[adc_ctrl_pkg::BAND_GAP_BIT];
      ctl1_r.ref_source <= wbyte[adc_ctrl_pkg::REF_SOURCE_BIT];
      ctl1_r.clk_div <= wbyte[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_enable_r <= '1;
    end else if (wr_commit && paddr_i == adc_ctrl_pkg::PIN_ENABLE_ADDR) begin
      pin_enable_r <= wbyte[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_mask_r <= 1'b0;
    end else if (wr_commit && paddr_i == adc_ctrl_pkg::IRQ_MASK_ADDR) begin
      irq_mask_r <= wbyte[adc_ctrl_pkg::IRQ_DONE_BIT];
    end
  end

  // Converter clock divider: 2**code system clocks per tick for codes 0 to 6; code 111 gives 64 like code 110
  always_comb begin
    case (ctl1_r.clk_div)
      3'h0: div_limit = 6'h00;
      3'h1: div_limit = 6'h01;
      3'h2: div_limit = 6'h03;
      3'h3: div_limit = 6'h07;
      3'h4: div_limit = 6'h0F;
      3'h5: div_limit = 6'h1F;
      3'h6: div_limit = 6'h3F;
      default: div_limit = 6'h3F; // Code 111 is unusable; treated as slowest
    endcase
  end
  assign div_tick = (div_cnt_r >= div_limit);

  // Counter runs only while converting, so every conversion starts phase aligned

  always_ff @(posedge clk_i) begin
    if (srst_i || state_r != CONVERT || div_tick) begin
      div_cnt_r <= 6'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // Conversion sequencer
  // Start high or power-down wins over everything; start release arms one sample
  // The twelfth converter clock tick ends the conversion
  assign done_pulse = (state_r == CONVERT) && div_tick && (bit_cnt_r == adc_ctrl_pkg::CONV_CLOCKS - 4'h1);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= IDLE;
      bit_cnt_r <= 4'h0;
      armed_r <= 1'b0;
      ctl0_r.pending <= 1'b1;
    end else if (ctl0_r.start || ctl0_r.power_down) begin
      state_r <= IDLE;
      bit_cnt_r <= 4'h0;
      armed_r <= ctl0_r.start;
      if (ctl0_r.start) begin
        ctl0_r.pending <= 1'b1;
      end
    end else if (armed_r) begin
      armed_r <= 1'b0;
      state_r <= CONVERT;
      ctl0_r.pending <= 1'b1;
    end else if (state_r == CONVERT && div_tick) begin
      if (done_pulse) begin
        state_r <= IDLE;
        ctl0_r.pending <= 1'b0;
      end
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_r <= '0;
    end else if (done_pulse) begin
      result_r <= core_result_i;
    end
  end

  // Sticky interrupt status: set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_status_r <= 1'b0;
    end else if (done_pulse) begin
      irq_status_r <= 1'b1;
    end else if (wr_en && pready_o && paddr_i == adc_ctrl_pkg::IRQ_STATUS_ADDR
        && wbyte[adc_ctrl_pkg::IRQ_DONE_BIT]) begin
      irq_status_r <= 1'b0;
    end
  end

  // Core control: reset, power and conversion strobes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      core_reset_o <= 1'b1;
      core_power_down_o <= 1'b1;
      core_clk_en_o <= 1'b0;
      core_sample_o <= 1'b0;
    end else begin
      core_reset_o <= ctl0_r.start || ctl0_r.power_down;
      core_power_down_o <= ctl0_r.power_down;
      core_clk_en_o <= (state_r == CONVERT) && div_tick;
      core_sample_o <= armed_r && !ctl0_r.start && !ctl0_r.power_down;
    end
  end

  // Input routing and reference selection; one source reaches the core
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      core_channel_o <= 3'h0;
      core_band_gap_sel_o <= 1'b0;
      band_gap_enable_o <= 1'b0;
      reference_source_select_o <= 1'b0;
    end else begin
      core_channel_o <= ctl0_r.channel;
      core_band_gap_sel_o <= ctl1_r.int_ref;
      band_gap_enable_o <= ctl1_r.band_gap;
      reference_source_select_o <= ctl1_r.ref_source;
    end
  end

  // Shared pin configuration
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_analog_o <= '1;
      pull_high_block_o <= '1;
    end else begin
      pin_analog_o <= pin_enable_r;
      pull_high_block_o <= pin_enable_r;
    end
  end

  // Level interrupt line
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_status_r && irq_mask_r;
    end
  end
endmodule // adc_control_and_result_regs

//--- inc/adc_ctrl_pkg.sv
// Package: register map, field layout, reset values and structs of the converter control block
package adc_ctrl_pkg;
  // Register byte addresses (one aligned word each)
  localparam logic [11:0] RESULT_LOW_ADDR = 12'h000;
  localparam logic [11:0] RESULT_HIGH_ADDR = 12'h004;
  localparam logic [11:0] CONTROL_0_ADDR = 12'h008;
  localparam logic [11:0] CONTROL_1_ADDR = 12'h00C;
  localparam logic [11:0] PIN_ENABLE_ADDR = 12'h010;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h014;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h018;
  // Control 0 fields
  localparam int START_BIT = 7;
  localparam int PENDING_BIT = 6;
  localparam int POWER_DOWN_BIT = 5;
  localparam int JUSTIFY_BIT = 4;
  localparam logic [7:0] CONTROL_0_WMASK = 8'hB7;
  localparam logic [7:0] CONTROL_0_RESET = 8'h60;
  // Control 1 fields
  localparam int INT_REF_BIT = 7;
  localparam int BAND_GAP_BIT = 6;
  localparam int REF_SOURCE_BIT = 4;
  localparam logic [7:0] CONTROL_1_WMASK = 8'hD7;
  localparam logic [7:0] CONTROL_1_RESET = 8'h00;
  localparam logic [7:0] PIN_ENABLE_RESET = 8'hFF;
  localparam logic [2:0] CLOCK_CODE_UNUSED = 3'h7;
  // Conversion length in converter clock periods
  localparam logic [3:0] CONV_CLOCKS = 4'hC;
  // Interrupt status bit: end of conversion
  localparam int IRQ_DONE_BIT = 0;

  typedef struct packed {
    logic start;
    logic pending;
    logic power_down;
    logic justify;
    logic [2:0] channel;
  } control_0_s;

  typedef struct packed {
    logic int_ref;
    logic band_gap;
    logic ref_source;
    logic [2:0] clk_div;
  } control_1_s;
endpackage

//--- verif/adc_core_model.sv
// Behavioural analog core: returns a code tagged with the routed source
`timescale 1ns/1ps
module adc_core_model (
  // Clock
  input wire logic clk_i,
  // Control from the block
  input wire logic rst_i,
  input wire logic smp_i,
  input wire logic [2:0] ch_i,
  input wire logic bg_i,
  // Result to the block
  output logic [11:0] res_o = 12'h000
);
  logic [7:0] seq_r = 8'h00;
  always @(posedge clk_i) begin
    if (smp_i) begin
      res_o <= {bg_i, ch_i, seq_r};
      seq_r <= seq_r + 8'h01;
    end else if (rst_i) begin
      res_o <= ~res_o;
    end
  end
endmodule // adc_core_model

//--- verif/adc_control_and_result_regs_chk.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_control_and_result_regs_chk #(
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Core, pins, interrupt
  input wire logic core_reset_o,
  input wire logic core_power_down_o,
  input wire logic core_sample_o,
  input wire logic [PIN_COUNT-1:0] pin_analog_o,
  input wire logic [PIN_COUNT-1:0] pull_high_block_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_pull_follow: assert property (pin_analog_o == pull_high_block_o)
    else $error("pull-high block differs from analog enable");
  a_pwrdn_reset: assert property (core_power_down_o |-> core_reset_o)
    else $error("core not held in reset while powered down");
  a_sample_powered: assert property (core_sample_o |-> !core_power_down_o)
    else $error("conversion began while powered down");
  a_sample_gap: assert property (core_sample_o |=> !core_sample_o [*8])
    else $error("conversion restarted too soon");
  a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_unmapped_err: assert property (pready_o && paddr_i > 12'h018 |-> pslverr_o)
    else $error("unmapped access not flagged");
  a_reset_state: assert property (disable iff (1'b0) srst_i |=> core_reset_o && core_power_down_o && !irq_o
    && pin_analog_o == '1)
    else $error("reset state wrong");
  c_sample: cover property (core_sample_o);
  c_error: cover property (pslverr_o);
  c_irq_clear: cover property (irq_o ##1 !irq_o);
endmodule // adc_control_and_result_regs_chk

//--- verif/adc_control_and_result_regs_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_and_result_regs_bench;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d, x; logic er;} row_s;
  logic clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
  logic [11:0] paddr_i = 12'h000, core_result_i, x;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, core_reset_o, core_power_down_o, core_clk_en_o, core_sample_o;
  logic core_band_gap_sel_o, band_gap_enable_o, reference_source_select_o, irq_o;
  logic [2:0] core_channel_o;
  logic [7:0] pin_analog_o, pull_high_block_o, r, c0, c1;
  int error_cnt = 0, tests_run = 0, cyc = 0, t0, ticks = 0, n0;
  row_s rows[8] = '{'{0, 12'h008, 8'h00, 8'h60, 0}, '{0, 12'h00C, 8'h00, 8'h00, 0},
    '{0, 12'h010, 8'h00, 8'hFF, 0}, '{1, 12'h00C, 8'hFF, 8'hD7, 0}, '{1, 12'h008, 8'h4F, 8'h47, 0},
    '{1, 12'h010, 8'h5A, 8'h5A, 0}, '{1, 12'h018, 8'h01, 8'h01, 0}, '{1, 12'h020, 8'hFF, 8'h00, 1}};
  adc_control_and_result_regs i_dut (.*);
  adc_core_model i_core (.clk_i(clk_i), .rst_i(core_reset_o), .smp_i(core_sample_o), .ch_i(core_channel_o),
    .bg_i(core_band_gap_sel_o), .res_o(core_result_i));
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o[7:0];
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic chk(input string n, input logic [11:0] g, input logic [11:0] w);
    tests_run++;
    if (g !== w) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, w, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end
  always @(posedge clk_i) begin
    if (core_clk_en_o === 1'b1) ticks <= ticks + 1;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 0;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 8'h00);
      chk("reg", r, rows[i].x);
      chk("err", e, rows[i].er);
    end
    chk("pins", pin_analog_o, 8'h5A);
    chk("pull", pull_high_block_o, 8'h5A);
    $display("table done");
    for (int k = 0; k < 7; k++) begin
      c1 = {k == 6, k == 6, 1'b0, k == 5, 1'b0, 3'(k)};
      c0 = {3'h0, 1'(k), 1'h0, 3'(k) ^ 3'h5};
      x = {k == 6, 3'(k) ^ 3'h5, 8'(k)};
      apb(1, 12'h00C, c1);
      apb(1, 12'h008, c0 | 8'h80);
      apb(0, 12'h008, 8'h00);
      chk("pend_hi", r[6], 1);
      chk("core_rst", core_reset_o, 1);
      chk("channel", core_channel_o, 3'(k) ^ 3'h5);
      chk("bg_sel", core_band_gap_sel_o, k == 6);
      chk("bg_en", band_gap_enable_o, k == 6);
      chk("ref_src", reference_source_select_o, k == 5);
      chk("pwr", core_power_down_o, 0);
      n0 = ticks;
      apb(1, 12'h008, c0);
      t0 = cyc;
      while (irq_o !== 1'b1) @(posedge clk_i);
      chk("time", cyc - t0 >= 12 << k && cyc - t0 <= (13 << k) + 6, 1);
      apb(0, 12'h008, 8'h00);
      chk("pend_lo", r[6], 0);
      chk("ticks", ticks - n0, 12);
      apb(1, 12'h000, 8'hFF);
      apb(0, 12'h004, 8'h00);
      chk("high", r, k[0] ? {4'h0, x[11:8]} : x[11:4]);
      apb(0, 12'h000, 8'h00);
      chk("low", r, k[0] ? x[7:0] : {x[3:0], 4'h0});
      if (k == 6) apb(1, 12'h018, 8'h00);
      apb(0, 12'h014, 8'h00);
      chk("status", r, 1);
      chk("irq", irq_o, k != 6);
      apb(1, 12'h014, 8'h01);
      apb(0, 12'h014, 8'h00);
      chk("cleared", r, 0);
      chk("irq_off", irq_o, 0);
      $display("conversion %0d done", k);
    end
    srst_i <= 1;
    repeat (3) @(posedge clk_i);
    srst_i <= 0;
    apb(0, 12'h008, 8'h00);
    chk("ctl0", r, 8'h60);
    chk("pins", pin_analog_o, 8'hFF);
    $display("reset done");
    give_verdict;
  end
endmodule // adc_control_and_result_regs_bench
bind adc_control_and_result_regs adc_control_and_result_regs_chk #(.PIN_COUNT(PIN_COUNT)) i_chk (.*);
